// ### logic/sfpi_cfg.svh
`ifndef SFPI_CFG_SVH
`define SFPI_CFG_SVH
`define SFPI_FIFO_WIDTH 8
`define SFPI_FIFO_DEPTH 32
`define SFPI_READ_OPCODE 8'h03
`define SFPI_DUAL_OPCODE 8'h3b
`define SFPI_LEAD_LAST 3'h3
`define SFPI_IDLE_BYTE 8'hff
`define SFPI_LAST_BIT 3'h7
`define SFPI_DUAL_LAST 3'h3
`endif

// ### logic/sfpi_pkg.sv
`default_nettype none
package sfpi_pkg;
  typedef enum logic [2:0] {
    MODE_CMD,
    MODE_LEAD,
    MODE_OUT_ONE,
    MODE_OUT_TWO,
    MODE_IN
  } sfpi_mode_type;

  typedef struct packed {
    logic dual_lane_one;
    logic dual_lane_one_oe;
    logic dual_lane_zero;
    logic dual_lane_zero_oe;
  } sfpi_pins_type;
endpackage
`default_nettype wire

// ### logic/sfpi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_cfg.svh"

// dual-clock fifo with gray pointers; it is also the crossing for read data
module sfpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  input wire logic rd_clk,
  input wire logic rd_rst,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_q;
  logic [AW:0] wgray_q;
  logic [AW:0] wbin_d;
  logic [AW:0] wgray_d;
  logic [AW:0] rg_s1_q;
  logic [AW:0] rg_s2_q;
  logic [AW:0] rbin_q;
  logic [AW:0] rgray_q;
  logic [AW:0] rbin_d;
  logic [AW:0] rgray_d;
  logic [AW:0] wg_s1_q;
  logic [AW:0] wg_s2_q;
  logic push;
  logic pop;
  logic full_d;
  logic empty_d;

  assign push = wr_valid && wr_ready;
  assign wbin_d = wbin_q + {{AW{1'b0}}, push};
  assign wgray_d = wbin_d ^ (wbin_d >> 1);
  assign full_d = (wgray_d == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      wr_ready <= 1'b1;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      wr_ready <= !full_d;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  assign pop = rd_ready && rd_valid;
  assign rbin_d = rbin_q + {{AW{1'b0}}, pop};
  assign rgray_d = rbin_d ^ (rbin_d >> 1);
  assign empty_d = (rgray_d == wg_s2_q);
  assign rd_data = mem[rbin_q[AW-1:0]];

  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin_q <= '0;
      rgray_q <= '0;
      rd_valid <= 1'b0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      rd_valid <= !empty_d;
    end
  end

  // read clock stops outside frames, so the write pointer view can lag
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule

module sfpi_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output var sfpi_pkg::sfpi_pins_type pins_q,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic busy,
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  output logic selected_q,
  output logic standby_q,
  output logic frame_end_q
);
  sfpi_pkg::sfpi_mode_type mode_q;
  logic link_rst;
  logic sck_n;
  logic dual_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] byte_w;
  logic [7:0] rx_hold_q;
  logic rx_tog_q;
  logic [7:0] sh_q;
  logic [2:0] out_cnt_q;
  logic [7:0] cur;
  logic fifo_pop;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;

  // chip select high holds the decode and output logic in reset, but not the receive hold and toggle
  assign link_rst = rst | cs_n;
  assign sck_n = ~sck;
  assign byte_w = {shift_q, si};

  sfpi_fifo #(
    .WIDTH(`SFPI_FIFO_WIDTH),
    .DEPTH(`SFPI_FIFO_DEPTH)
  ) u_tx_fifo (
    .wr_clk(ref_clk),
    .wr_rst(rst),
    .wr_valid(tx_valid),
    .wr_data(tx_data),
    .wr_ready(tx_ready),
    .rd_clk(sck_n),
    .rd_rst(rst),
    .rd_ready(fifo_pop),
    .rd_valid(fifo_valid),
    .rd_data(fifo_data)
  );

  // opcode and lead-in decode on rising clock; counters restart per frame
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      mode_q <= sfpi_pkg::MODE_CMD;
      dual_q <= 1'b0;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (mode_q != sfpi_pkg::MODE_OUT_TWO) begin
      shift_q <= byte_w[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == `SFPI_LAST_BIT) begin
        case (mode_q)
          sfpi_pkg::MODE_CMD: begin
            if (byte_w == `SFPI_READ_OPCODE) begin
              mode_q <= sfpi_pkg::MODE_LEAD;
              dual_q <= 1'b0;
            end else if (byte_w == `SFPI_DUAL_OPCODE) begin
              mode_q <= sfpi_pkg::MODE_LEAD;
              dual_q <= 1'b1;
            end else begin
              mode_q <= sfpi_pkg::MODE_IN;
            end
          end
          sfpi_pkg::MODE_LEAD: begin
            if (byte_cnt_q == `SFPI_LEAD_LAST) begin
              mode_q <= dual_q ? sfpi_pkg::MODE_OUT_TWO : sfpi_pkg::MODE_OUT_ONE;
            end else begin
              byte_cnt_q <= byte_cnt_q + 3'h1;
            end
          end
          default: begin
            mode_q <= mode_q;
          end
        endcase
      end
    end
  end

  // not reset by chip select, else the toggle would fake a byte
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rx_hold_q <= 8'h00;
      rx_tog_q <= 1'b0;
    end else if (mode_q != sfpi_pkg::MODE_OUT_TWO && bit_cnt_q == `SFPI_LAST_BIT) begin
      rx_hold_q <= byte_w;
      rx_tog_q <= ~rx_tog_q;
    end
  end

  // an empty fifo sends idle ones rather than stalling the host clock
  always_comb begin
    fifo_pop = 1'b0;
    cur = sh_q;
    if ((mode_q == sfpi_pkg::MODE_OUT_ONE || mode_q == sfpi_pkg::MODE_OUT_TWO) &&
        out_cnt_q == 3'h0) begin
      cur = fifo_valid ? fifo_data : `SFPI_IDLE_BYTE;
      fifo_pop = fifo_valid;
    end
  end

  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      pins_q <= '0;
      sh_q <= 8'h00;
      out_cnt_q <= 3'h0;
    end else begin
      case (mode_q)
        sfpi_pkg::MODE_OUT_ONE: begin
          pins_q.dual_lane_one <= cur[7];
          pins_q.dual_lane_one_oe <= 1'b1;
          pins_q.dual_lane_zero <= 1'b0;
          pins_q.dual_lane_zero_oe <= 1'b0;
          sh_q <= {cur[6:0], 1'b0};
          out_cnt_q <= out_cnt_q + 3'h1;
        end
        sfpi_pkg::MODE_OUT_TWO: begin
          pins_q.dual_lane_one <= cur[7];
          pins_q.dual_lane_one_oe <= 1'b1;
          pins_q.dual_lane_zero <= cur[6];
          pins_q.dual_lane_zero_oe <= 1'b1;
          sh_q <= {cur[5:0], 2'b00};
          out_cnt_q <= (out_cnt_q == `SFPI_DUAL_LAST) ? 3'h0 : out_cnt_q + 3'h1;
        end
        default: begin
          pins_q <= '0;
          sh_q <= 8'h00;
          out_cnt_q <= 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selected_q <= 1'b0;
      standby_q <= 1'b1;
      frame_end_q <= 1'b0;
    end else begin
      selected_q <= ~cs_s2_q;
      standby_q <= cs_s2_q & ~busy;
      frame_end_q <= cs_s2_q & ~cs_s3_q;
    end
  end

  // the hold register stays stable for eight link clocks after the toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      tog_s1_q <= rx_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      rx_valid_q <= tog_s2_q ^ tog_s3_q;
      if (tog_s2_q ^ tog_s3_q) begin
        rx_data_q <= rx_hold_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/serial_flash_spi_pin_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_pin_interface_tb;
  logic ref_clk, rst, busy, tx_valid, tx_ready, rx_valid_q, selected_q, standby_q;
  logic cs_n, sck, hsi, si, so, frame_end_q;
  logic [7:0] tx_data, rx_data_q, r;
  sfpi_pkg::sfpi_pins_type pins_q;
  int miscompares, check_count;
  assign so = pins_q.dual_lane_one_oe ? pins_q.dual_lane_one : 1'bz;
  assign si = pins_q.dual_lane_zero_oe ? pins_q.dual_lane_zero : hsi;
  sfpi_top DUT (.ref_clk, .rst, .cs_n, .sck, .si, .pins_q, .tx_data, .tx_valid,
    .tx_ready, .busy, .rx_data_q, .rx_valid_q, .selected_q, .standby_q, .frame_end_q);
  sfpi_host host (.cs_n, .sck, .si(hsi), .so, .io0(si));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic push(input logic [7:0] b);
    @(negedge ref_clk);
    tx_data = b;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask
  // fill until refused, then drain with host stalls
  task automatic t_fill_read;
    int n;
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      tx_data = 8'(n * 37 + 1);
      tx_valid = 1'b1;
      if (tx_ready) n++;
    end
    @(negedge ref_clk);
    tx_valid = 1'b0;
    cmp(8'(n), 8'h20);
    host.open_f;
    host.xfer(8'h03, 1'b0, r);
    repeat (4) host.xfer(8'h00, 1'b0, r);
    cmp(8'(selected_q), 8'h01);
    for (int i = 0; i < 33; i++) begin
      host.xfer(8'h00, 1'b0, r);
      cmp(r, i < 32 ? 8'(i * 37 + 1) : 8'hff);
      #200;
    end
    host.close_f;
  endtask
  task automatic t_dual;
    push(8'h96);
    push(8'hc3);
    host.open_f;
    host.xfer(8'h3b, 1'b0, r);
    repeat (4) host.xfer(8'h00, 1'b0, r);
    host.xfer(8'h00, 1'b1, r);
    cmp(r, 8'h96);
    host.xfer(8'h00, 1'b1, r);
    cmp(r, 8'hc3);
    host.close_f;
  endtask
  // wiggles while deselected, a cut byte, then a fresh opcode
  task automatic t_desel;
    int fe;
    int rv;
    fe = 0;
    rv = 0;
    host.clk_only(8);
    repeat (6) @(negedge ref_clk);
    cmp(rx_data_q, 8'h00);
    host.open_f;
    host.clk_only(3);
    host.close_f;
    host.open_f;
    host.xfer(8'h5a, 1'b0, r);
    // pulses are counted across the close so none is missed
    fork
      host.close_f;
      begin
        repeat (8) begin
          @(negedge ref_clk);
          fe += int'(frame_end_q === 1'b1);
          rv += int'(rx_valid_q === 1'b1);
        end
      end
    join
    cmp(rx_data_q, 8'h5a);
    cmp(8'(fe), 8'h01);
    cmp(8'(rv), 8'h01);
  endtask
  task automatic t_busy;
    @(negedge ref_clk);
    busy = 1'b1;
    repeat (4) @(negedge ref_clk);
    cmp(8'(standby_q), 8'h00);
    busy = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmp(8'(standby_q), 8'h01);
  endtask
  initial begin
    #2000000;
    miscompares++;
    wrap_up;
  end
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_fill_read;
    t_dual;
    t_desel;
    t_busy;
    wrap_up;
  end
endmodule
`default_nettype wire

// ### verification/sfpi_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sfpi_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire sfpi_pkg::sfpi_pins_type pins_q,
  input wire logic busy,
  input wire logic rx_valid_q,
  input wire logic selected_q,
  input wire logic standby_q,
  input wire logic frame_end_q
);
  // pins seen at sck rise must still stand at the next fall
  sfpi_pkg::sfpi_pins_type hold_q;
  always_ff @(posedge sck) hold_q <= pins_q;
  property p_hiz;
    @(posedge ref_clk) disable iff (rst)
      cs_n |-> !pins_q.dual_lane_one_oe && !pins_q.dual_lane_zero_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while deselected");
  property p_sel;
    @(posedge ref_clk) disable iff (rst) cs_n [*5] |-> !selected_q;
  endproperty
  a_sel: assert property (p_sel) else $error("selected without chip select");
  property p_stb;
    @(posedge ref_clk) disable iff (rst) (cs_n && !busy) [*6] |-> standby_q;
  endproperty
  a_stb: assert property (p_stb) else $error("no standby when idle");
  property p_busy;
    @(posedge ref_clk) disable iff (rst) busy [*3] |-> !standby_q;
  endproperty
  a_busy: assert property (p_busy) else $error("standby while busy");
  property p_end;
    @(posedge ref_clk) disable iff (rst) $rose(cs_n) |-> ##[2:5] frame_end_q;
  endproperty
  a_end: assert property (p_end) else $error("frame end missing");
  property p_rxq;
    @(posedge ref_clk) disable iff (rst) cs_n [*8] |-> !rx_valid_q;
  endproperty
  a_rxq: assert property (p_rxq) else $error("byte taken while deselected");
  property p_dual;
    @(posedge ref_clk) disable iff (rst)
      pins_q.dual_lane_zero_oe |-> pins_q.dual_lane_one_oe;
  endproperty
  a_dual: assert property (p_dual) else $error("lane one not driven in dual");
  property p_fall;
    @(negedge sck) disable iff (rst || cs_n) pins_q == hold_q;
  endproperty
  a_fall: assert property (p_fall) else $error("output moved off a fall");
endmodule
bind sfpi_top sfpi_checker u_chk (.ref_clk, .rst, .cs_n, .sck, .pins_q, .busy,
  .rx_valid_q, .selected_q, .standby_q, .frame_end_q);
`default_nettype wire

// ### verification/sfpi_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
  output var logic cs_n,
  output var logic sck,
  output var logic si,
  input wire logic so,
  input wire logic io0
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic open_f;
    #20 cs_n = 1'b0;
    #30;
  endtask
  task automatic close_f;
    #30 cs_n = 1'b1;
    #60;
  endtask
  // si toggles when unused: no pull holds it
  task automatic clk_only(input int k);
    repeat (k) begin
      si = ~si;
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] o, input logic dual, output logic [7:0] r);
    for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
      si = dual ? ~si : o[i];
      #24 sck = 1'b1;
      r[i] = so;
      if (dual) r[i-1] = io0;
      #24 sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
